// file: sdd_core.sv
// speed detection, display scaling and output terminal logic
`timescale 1ns/100ps
`default_nettype none
module sdd_core
   import sdd_pkg::*;
(
   input  wire logic         clk_i,
   input  wire logic         nrst_i,
   input  wire logic         psel_i,
   input  wire logic         penable_i,
   input  wire logic         pwrite_i,
   input  wire logic [7:0]   paddr_i,
   input  wire logic [31:0]  pwdata_i,
   output logic      [31:0]  prdata_o,
   output logic              pready_o,
   output logic              pslverr_o,
   input  wire sdd_mode_t    mode_i,
   input  wire logic         start_i,
   input  wire logic         output_stop_input_i,
   input  wire logic         fault_clear_input_i,
   input  wire logic         alarm_i,
   input  wire logic [15:0]  cmd_speed_i,
   input  wire logic [15:0]  meas_speed_i,
   input  wire logic [15:0]  freq_speed_i,
   output logic      [11:0]  speed_ref_o,
   output sdd_flags_t        flags_o,
   output sdd_disp_t         run_disp_o,
   output sdd_disp_t         preset_disp_o,
   output logic              open_collector_out_1_o,
   output logic              open_collector_out_2_o,
   output logic              open_collector_out_3_o,
   output logic              relay_contact_output_o
);

   //************************************************************
   // helper functions
   //************************************************************

   // magnitude of a signed speed, saturated to 15 bits
   function automatic logic [14:0] mag(input logic [15:0] s);
      logic [15:0] n;
      n = s[15] ? 16'(-s) : s;
      mag = n[15] ? MAG_MAX : n[14:0];
   endfunction

   // one detection level with direction-dependent threshold
   function automatic logic lvl(input logic [15:0] s,
                                input logic [11:0] f,
                                input logic [11:0] r,
                                input logic        st);
      logic [11:0] t;
      t = s[15] ? r : f;
      lvl = (t == 12'h000) ? st : (mag(s) >= 15'(t));
   endfunction

   // scale a speed magnitude to the panel unit
   function automatic sdd_disp_t to_disp(input logic [14:0] s,
                                         input logic [13:0] m,
                                         input logic [3:0]  p,
                                         input logic [11:0] r);
      logic [28:0] w;
      sdd_disp_t   d;
      w = 29'(s);
      d.unit = SDD_U_RPM;
      if (m != R_MACH)
      begin
         w = (29'(s) * 29'(m)) / 29'(r);
         d.unit = SDD_U_MACH;
      end
      else if (p != R_POLE)
      begin
         w = (29'(s) * 29'(p) * 29'(HZ_NUM)) / 29'(HZ_DEN);
         d.unit = SDD_U_HZ;
      end
      d.ovf = w > 29'(DISP_MAX);
      d.val = d.ovf ? 14'h0000 : w[13:0];
      to_disp = d;
   endfunction

   // pick one flag for an output terminal
   function automatic logic flag_of(input logic [2:0] sel,
                                    input sdd_flags_t f);
      logic [6:0] v;
      v = {f.measured_speed_level_flag, f.command_speed_level_flag,
           f.at_setpoint_flag};
      flag_of = (sel == T_NONE) ? 1'b0 : v[sel - 3'h1];
   endfunction

   //************************************************************
   // declarations
   //************************************************************
   logic [13:0] mach_q;
   logic [3:0]  poles_q;
   logic [11:0] ref_q;
   logic [6:0]  sens_q;
   logic [11:0] th1_q;
   logic [13:0] trv_q;
   logic [11:0] th2_q;
   logic [11:0] th3_q;
   logic [13:0] setv_q;
   logic [11:0] osel_q;
   logic [31:0] rd_q;
   sdd_flags_t  flags_q;
   sdd_disp_t   run_q;
   sdd_disp_t   pre_q;
   logic [11:0] sref_q;
   logic [3:0]  term_q;
   logic [2:0]  pin_w;
   logic [2:0]  pin_s;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);

   //************************************************************
   // pin synchronisers
   //************************************************************

   // three stages; a level is taken once stages two and three agree
   assign pin_w = {fault_clear_input_i, output_stop_input_i, start_i};

   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_sync
         logic [2:0] sh_q;
         logic       st_q;
         always_ff @(posedge clk_i or negedge nrst_i)
         begin
            if (!nrst_i)
            begin
               sh_q <= 3'h0;
               st_q <= 1'b0;
            end
            else
            begin
               sh_q <= {sh_q[1:0], pin_w[g]};
               if (sh_q[1] == sh_q[2])
                  st_q <= sh_q[2];
            end
         end
         assign pin_s[g] = st_q;
      end
   endgenerate

   logic start_s;
   logic kill_w;
   assign start_s = pin_s[0];
   assign kill_w  = alarm_i | pin_s[1] | pin_s[2];

   //************************************************************
   // APB register access
   //************************************************************
   logic s_mach, s_pole, s_ref, s_sens, s_th1, s_trv, s_th2;
   logic s_th3, s_setv, s_osel, s_stat, s_run, s_pre, s_sref;
   logic map_w, wok_w, acc_w, wr_w;
   logic ok_th_w;

   // address decode
   assign s_mach = paddr_i == A_MACH;
   assign s_pole = paddr_i == A_POLE;
   assign s_ref  = paddr_i == A_REF;
   assign s_sens = paddr_i == A_SENS;
   assign s_th1  = paddr_i == A_TH1;
   assign s_trv  = paddr_i == A_TRV;
   assign s_th2  = paddr_i == A_TH2;
   assign s_th3  = paddr_i == A_TH3;
   assign s_setv = paddr_i == A_SETV;
   assign s_osel = paddr_i == A_OSEL;
   assign s_stat = paddr_i == A_STAT;
   assign s_run  = paddr_i == A_RUN;
   assign s_pre  = paddr_i == A_PRE;
   assign s_sref = paddr_i == A_SREF;
   assign map_w  = s_mach | s_pole | s_ref | s_sens | s_th1 | s_trv |
                   s_th2 | s_th3 | s_setv | s_osel | s_stat | s_run |
                   s_pre | s_sref;

   // write value checks; out of range writes are refused
   assign ok_th_w = pwdata_i <= 32'(SPD_MAX);
   assign wok_w =
      (s_mach & (pwdata_i <= 32'(MACH_MAX))) |
      (s_pole & (pwdata_i <= 32'(POLE_MAX)) & ~pwdata_i[0]) |
      (s_ref  & (pwdata_i <= 32'(SPD_MAX)) &
                (pwdata_i != 32'h0000_0000)) |
      (s_sens & (pwdata_i <= 32'(PCT_FULL))) |
      ((s_th1 | s_th2 | s_th3) & ok_th_w) |
      (s_trv  & (ok_th_w | (pwdata_i == 32'(REV_SAME)))) |
      (s_setv & (pwdata_i <= 32'(DISP_MAX))) |
      (s_osel & (pwdata_i[31:12] == 20'h0_0000));

   assign acc_w     = psel_i & penable_i;
   assign wr_w      = acc_w & pwrite_i & wok_w;
   assign pready_o  = acc_w;
   assign pslverr_o = acc_w & (~map_w | (pwrite_i & ~wok_w));
   assign prdata_o  = rd_q;

   // read mux, captured in the setup cycle
   logic [31:0] rmux_w;
   assign rmux_w =
      s_mach ? 32'(mach_q)  : s_pole ? 32'(poles_q) :
      s_ref  ? 32'(ref_q)   : s_sens ? 32'(sens_q)  :
      s_th1  ? 32'(th1_q)   : s_trv  ? 32'(trv_q)   :
      s_th2  ? 32'(th2_q)   : s_th3  ? 32'(th3_q)   :
      s_setv ? 32'(setv_q)  : s_osel ? 32'(osel_q)  :
      s_stat ? 32'(flags_q) : s_run  ? 32'(run_q)   :
      s_pre  ? 32'(pre_q)   : s_sref ? 32'(sref_q)  : 32'h0000_0000;

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rd_q <= 32'h0000_0000;
      else if (psel_i & ~penable_i)
         rd_q <= rmux_w;
   end

   // configuration registers
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         mach_q  <= R_MACH;
         poles_q <= R_POLE;
         ref_q   <= R_REF;
         sens_q  <= R_SENS;
         th1_q   <= R_TH1;
         trv_q   <= R_TRV;
         th2_q   <= R_TH2;
         th3_q   <= R_TH3;
         setv_q  <= R_SETV;
         osel_q  <= R_OSEL;
      end
      else if (wr_w)
      begin
         if (s_mach) mach_q  <= pwdata_i[13:0];
         if (s_pole) poles_q <= pwdata_i[3:0];
         if (s_ref)  ref_q   <= pwdata_i[11:0];
         if (s_sens) sens_q  <= pwdata_i[6:0];
         if (s_th1)  th1_q   <= pwdata_i[11:0];
         if (s_trv)  trv_q   <= pwdata_i[13:0];
         if (s_th2)  th2_q   <= pwdata_i[11:0];
         if (s_th3)  th3_q   <= pwdata_i[11:0];
         if (s_setv) setv_q  <= pwdata_i[13:0];
         if (s_osel) osel_q  <= pwdata_i[11:0];
      end
   end

   //************************************************************
   // speed setting conversion
   //************************************************************
   sdd_unit_t   set_unit_w;
   logic [13:0] mden_w;
   logic [6:0]  hden_w;
   logic [6:0]  hdiv_w;
   logic [26:0] mrpm_w, hrpm_w, raw_w;
   logic [11:0] sref_w;

   // setting unit follows the display and pole settings
   assign set_unit_w =
      (mach_q != R_MACH) ? ((poles_q != R_POLE) ? SDD_U_MACH
                                                : SDD_U_RPM) :
      (poles_q != R_POLE) ? SDD_U_HZ : SDD_U_RPM;

   // divisions add half the divisor so results round to 1 r/min
   assign mden_w = (mach_q == R_MACH) ? 14'h0001 : mach_q;
   assign mrpm_w = (27'(setv_q) * 27'(ref_q) + 27'(mden_w >> 1))
                   / 27'(mden_w);
   assign hden_w = 7'(poles_q) * 7'(HZ_NUM);
   assign hdiv_w = (poles_q == R_POLE) ? 7'h01 : hden_w;
   assign hrpm_w = (27'(setv_q) * 27'(HZ_DEN) + 27'(hdiv_w >> 1))
                   / 27'(hdiv_w);
   assign raw_w  = (set_unit_w == SDD_U_MACH) ? mrpm_w :
                   (set_unit_w == SDD_U_HZ)   ? hrpm_w : 27'(setv_q);
   assign sref_w = (raw_w > 27'(SPD_MAX)) ? SPD_MAX : raw_w[11:0];
   assign speed_ref_o = sref_q;

   //************************************************************
   // speed sources, levels and up-to-speed band
   //************************************************************
   logic        vf_w, cmd_en_w;
   logic [15:0] cmd_src_w, meas_src_w;
   logic [14:0] fbm_w, diff_w;
   logic [18:0] band_w;
   logic        su_w;
   logic [11:0] thf_w [3];
   logic [11:0] thr_w [3];
   logic [2:0]  cmd_hit_w, meas_hit_w;

   // V/F mode replaces both sources by the frequency-derived speed
   assign vf_w       = mode_i == SDD_M_VF;
   assign cmd_en_w   = (mode_i == SDD_M_SPEED) | vf_w;
   assign cmd_src_w  = vf_w ? freq_speed_i : cmd_speed_i;
   assign meas_src_w = vf_w ? freq_speed_i : meas_speed_i;

   // band is a share of the running setting
   assign fbm_w  = mag(meas_src_w);
   assign diff_w = (fbm_w >= 15'(sref_w)) ? fbm_w - 15'(sref_w)
                                          : 15'(sref_w) - fbm_w;
   assign band_w = (19'(sref_w) * 19'(sens_q)) / 19'(PCT_FULL);
   assign su_w   = start_s & (19'(diff_w) <= band_w);

   // thresholds per level; reverse uses forward on the same-code
   assign thf_w[0] = th1_q;
   assign thf_w[1] = th2_q;
   assign thf_w[2] = th3_q;
   assign thr_w[0] = (trv_q == REV_SAME) ? th1_q : trv_q[11:0];
   assign thr_w[1] = th2_q;
   assign thr_w[2] = th3_q;

   genvar k;
   generate
      for (k = 0; k < 3; k++)
      begin : g_lvl
         // zero threshold follows start inside lvl
         assign cmd_hit_w[k]  = cmd_en_w & ~kill_w &
            lvl(cmd_src_w, thf_w[k], thr_w[k], start_s);
         assign meas_hit_w[k] = ~kill_w &
            lvl(meas_src_w, thf_w[k], thr_w[k], start_s);
      end
   endgenerate

   //************************************************************
   // registered flags, displays and terminals
   //************************************************************

   // refreshed every control cycle
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         flags_q <= '0;
         run_q   <= '0;
         pre_q   <= '0;
         sref_q  <= 12'h000;
      end
      else
      begin
         flags_q <= {su_w, cmd_hit_w, meas_hit_w};
         run_q   <= to_disp(fbm_w, mach_q, poles_q, ref_q);
         pre_q   <= to_disp(15'(sref_w), mach_q, poles_q, ref_q);
         sref_q  <= sref_w;
      end
   end

   assign flags_o       = flags_q;
   assign run_disp_o    = run_q;
   assign preset_disp_o = pre_q;

   // assignable output terminals
   genvar t;
   generate
      for (t = 0; t < 4; t++)
      begin : g_term
         always_ff @(posedge clk_i or negedge nrst_i)
         begin
            if (!nrst_i)
               term_q[t] <= 1'b0;
            else
               term_q[t] <= flag_of(osel_q[3*t +: 3], flags_q);
         end
      end
   endgenerate

   assign open_collector_out_1_o = term_q[0];
   assign open_collector_out_2_o = term_q[1];
   assign open_collector_out_3_o = term_q[2];
   assign relay_contact_output_o = term_q[3];

   //************************************************************
   // assertions
   //************************************************************
   sequence s_stop_held;
      output_stop_input_i[*4];
   endsequence

   property p_stop_kills;
      s_stop_held |-> ##[1:2] (flags_q.measured_speed_level_flag == 3'h0);
   endproperty
   a_stop_kills: assert property (p_stop_kills)
      else $error("flags not cleared by output stop");

   property p_kill;
      kill_w |=> (flags_q.command_speed_level_flag == 3'h0) &&
                 (flags_q.measured_speed_level_flag == 3'h0);
   endproperty
   a_kill: assert property (p_kill)
      else $error("detection flag set during alarm or stop");

   property p_cmd_mode;
      (mode_i == SDD_M_TORQ || mode_i == SDD_M_POS)
         |=> (flags_q.command_speed_level_flag == 3'h0);
   endproperty
   a_cmd_mode: assert property (p_cmd_mode)
      else $error("command flag active in torque or position mode");

   property p_zero_start;
      (th2_q == 12'h000 && start_s && !kill_w)
         |=> flags_q.measured_speed_level_flag[1];
   endproperty
   a_zero_start: assert property (p_zero_start)
      else $error("zero threshold flag missing after start");

   property p_vf_same;
      (vf_w && !kill_w) |=> (flags_q.command_speed_level_flag ==
                             flags_q.measured_speed_level_flag);
   endproperty
   a_vf_same: assert property (p_vf_same)
      else $error("command and measured flags differ in V/F");

   property p_plain_rpm;
      (mach_q == R_MACH && poles_q == R_POLE && fbm_w <= 15'(DISP_MAX))
         |=> (run_q.unit == SDD_U_RPM) &&
             (run_q.val == $past(fbm_w[13:0])) && !run_q.ovf;
   endproperty
   a_plain_rpm: assert property (p_plain_rpm)
      else $error("plain speed display wrong");

   property p_ovf;
      (mach_q == R_MACH && poles_q == R_POLE && fbm_w > 15'(DISP_MAX))
         |=> run_q.ovf && (run_q.val == 14'h0000);
   endproperty
   a_ovf: assert property (p_ovf)
      else $error("overflow not shown above 9999");

   property p_units;
      (mach_q != R_MACH) |=> (run_q.unit == SDD_U_MACH) &&
                             (pre_q.unit == SDD_U_MACH);
   endproperty
   a_units: assert property (p_units)
      else $error("machine units not selected");

   property p_pole_rej;
      (acc_w && pwrite_i && s_pole && pwdata_i[0])
         |-> pslverr_o ##1 (poles_q == $past(poles_q));
   endproperty
   a_pole_rej: assert property (p_pole_rej)
      else $error("odd pole count accepted");

   property p_su;
      (start_s && 19'(diff_w) <= band_w) |=> flags_q.at_setpoint_flag;
   endproperty
   a_su: assert property (p_su)
      else $error("up-to-speed flag missing inside band");

endmodule
`default_nettype wire

// file: sdd_pkg.sv
// package: register map, limits and types of the speed monitor block
package sdd_pkg;
   //************************************************************
   // What this block does
   // - speed display 0 plain, 1-9998 machine units
   // - machine units scale linearly with reference speed
   // - reference speed 1..3600 r/min, default 1500
   // - pole count only 0,2,4,6,8,10; nonzero gives Hz when machine units are 0
   // - both zero r/min; poles only gives Hz
   // - machine mode: monitors machine units, setting unit varies
   // - Hz conversion uses display pole count only
   // - speed setting runs at matching synchronous speed
   // - values above 9999 show overflow instead
   // - setting converted in 1 r/min steps, rounded
   // - up-to-speed flag within band, 0..100%, default 10%
   // - up-to-speed uses measured feedback speed
   // - command flags use command, measured flags feedback
   // - level one: forward and reverse thresholds, default 300
   // - reverse threshold 9999 means use forward threshold
   // - level two threshold 750, both directions
   // - level three threshold 1500, both directions
   // - command flags only in speed or V/F mode
   // - V/F mode compares speed from output frequency
   // - alarm, output stop, fault clear force flags off; the at setpoint flag is not forced off
   // - zero threshold flag follows start command
   // - flags reach pins via assignable terminals
   //************************************************************

   // register byte addresses
   localparam logic [7:0]  A_MACH   = 8'h00;
   localparam logic [7:0]  A_POLE   = 8'h04;
   localparam logic [7:0]  A_REF    = 8'h08;
   localparam logic [7:0]  A_SENS   = 8'h0C;
   localparam logic [7:0]  A_TH1    = 8'h10;
   localparam logic [7:0]  A_TRV    = 8'h14;
   localparam logic [7:0]  A_TH2    = 8'h18;
   localparam logic [7:0]  A_TH3    = 8'h1C;
   localparam logic [7:0]  A_SETV   = 8'h20;
   localparam logic [7:0]  A_OSEL   = 8'h24;
   localparam logic [7:0]  A_STAT   = 8'h28;
   localparam logic [7:0]  A_RUN    = 8'h2C;
   localparam logic [7:0]  A_PRE    = 8'h30;
   localparam logic [7:0]  A_SREF   = 8'h34;
   // limits and scale factors
   localparam logic [13:0] MACH_MAX = 14'h270E;
   localparam logic [13:0] DISP_MAX = 14'h270F;
   localparam logic [13:0] REV_SAME = 14'h270F;
   localparam logic [11:0] SPD_MAX  = 12'h0E10;
   localparam logic [3:0]  POLE_MAX = 4'hA;
   localparam logic [6:0]  PCT_FULL = 7'h64;
   localparam logic [2:0]  HZ_NUM   = 3'h5;
   localparam logic [2:0]  HZ_DEN   = 3'h6;
   localparam logic [14:0] MAG_MAX  = 15'h7FFF;
   // reset values
   localparam logic [13:0] R_MACH   = 14'h0000;
   localparam logic [3:0]  R_POLE   = 4'h0;
   localparam logic [11:0] R_REF    = 12'h05DC;
   localparam logic [6:0]  R_SENS   = 7'h0A;
   localparam logic [11:0] R_TH1    = 12'h012C;
   localparam logic [13:0] R_TRV    = 14'h270F;
   localparam logic [11:0] R_TH2    = 12'h02EE;
   localparam logic [11:0] R_TH3    = 12'h05DC;
   localparam logic [13:0] R_SETV   = 14'h0000;
   localparam logic [11:0] R_OSEL   = 12'h014A;
   // terminal selector: 0 none, 1 at setpoint, 2-4 command, 5-7 measured
   localparam logic [2:0]  T_NONE   = 3'h0;

   typedef enum logic [1:0] {
      SDD_M_SPEED = 2'b00,
      SDD_M_VF    = 2'b01,
      SDD_M_TORQ  = 2'b10,
      SDD_M_POS   = 2'b11
   } sdd_mode_t;

   typedef enum logic [1:0] {
      SDD_U_RPM  = 2'b00,
      SDD_U_HZ   = 2'b01,
      SDD_U_MACH = 2'b10
   } sdd_unit_t;

   typedef struct packed {
      logic       at_setpoint_flag;
      logic [2:0] command_speed_level_flag;
      logic [2:0] measured_speed_level_flag;
   } sdd_flags_t;

   typedef struct packed {
      logic [13:0] val;
      logic        ovf;
      sdd_unit_t   unit;
   } sdd_disp_t;
endpackage

// file: sdd_enc.sv
// encoder model: feedback speed that follows a target
`timescale 1ns/100ps
`default_nettype none
module sdd_enc
(
   input  wire logic        clk_i,
   input  wire logic        slow_i,
   input  wire logic [15:0] tgt_i,
   output var  logic [15:0] spd_o = 16'h0000
);
   logic signed [15:0] gap_w;
   assign gap_w = $signed(tgt_i - spd_o);
   // slow mode slews 64 r/min a cycle, otherwise jumps at once
   always @(posedge clk_i)
   begin
      if (!slow_i || (gap_w >= -16'sh0040 && gap_w <= 16'sh0040))
         spd_o <= tgt_i;
      else if ($signed(tgt_i) > $signed(spd_o))
         spd_o <= spd_o + 16'h0040;
      else
         spd_o <= spd_o - 16'h0040;
   end
endmodule
`default_nettype wire

// file: tb.sv
// self-checking bench of the speed monitor block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin \
 $display("CHECK FAILED %s exp %h got %h", n, e, s); fail_count++; end end
module tb;
   import sdd_pkg::*;
   localparam logic [32:0] E = {1'b1, 32'h0000_0000};
   logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0;
   logic        pwr = 1'b0, st = 1'b0, stp = 1'b0, clr = 1'b0;
   logic        alm = 1'b0, slow = 1'b0, pready, pslverr;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic [15:0] cs = 16'h0000, ms = 16'h0000, fs = 16'h0000, meas;
   logic [3:0]  pins;
   logic [11:0] sref;
   logic [31:0] pv;
   sdd_flags_t  flg;
   sdd_disp_t   rdisp, pdisp;
   logic [32:0] q[$], ea, ep;
   sdd_mode_t   mode = SDD_M_SPEED;
   int fail_count = 0, n_tests = 0, trv = 9999, rs = 0, sp = 1000;
   int th[3] = '{300, 750, 1500};
   int bt[8] = '{300, 299, -300, 1100, -749, 1500, -1499, 899};
   event pin_ev;
   sdd_core sdd_core_inst(.clk_i(clk), .nrst_i(nrst), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .mode_i(mode), .start_i(st), .output_stop_input_i(stp),
      .fault_clear_input_i(clr), .alarm_i(alm), .cmd_speed_i(cs),
      .meas_speed_i(meas), .freq_speed_i(fs), .speed_ref_o(sref),
      .flags_o(flg), .run_disp_o(rdisp), .preset_disp_o(pdisp),
      .open_collector_out_1_o(pins[0]), .open_collector_out_2_o(pins[1]),
      .open_collector_out_3_o(pins[2]), .relay_contact_output_o(pins[3]));
   sdd_enc sdd_enc_inst(.clk_i(clk), .slow_i(slow), .tgt_i(ms),
      .spd_o(meas));
   always #20 clk = ~clk;
   //****************************************
   // expectations and checking
   //****************************************
   // detection flags of one source at the three levels
   function automatic logic [2:0] lv(int s);
      logic [2:0] r;
      int a, t;
      a = s < 0 ? -s : s;
      for (int k = 0; k < 3; k++)
      begin
         t = (k == 0 && s < 0 && trv != 9999) ? trv : th[k];
         r[k] = (t == 0) ? st : (a >= t);
      end
      return r;
   endfunction
   // whole flag word: at setpoint, command, measured
   function automatic logic [6:0] ef(int c, int m, int f);
      logic vf = (mode == SDD_M_VF);
      logic [2:0] a, b;
      int d;
      a = lv(vf ? f : c) & {3{mode == SDD_M_SPEED || vf}};
      b = lv(vf ? f : m);
      if (alm | stp | clr)
         {a, b} = 6'h00;
      d = vf ? f : m;
      d = (d < 0 ? -d : d) - sp;
      return {st && d <= sp / 10 && d >= -sp / 10, a, b};
   endfunction
   // watcher pops the oldest note whenever a result appears
   always @(posedge clk)
      if (psel && pen && pready)
      begin
         ea = q.pop_front();
         `CHK("apb", ea, {pslverr, pwr ? 32'h0000_0000 : prdata})
         // the monitor ports must agree with the expected register value
         pv = paddr == A_RUN ? {15'h0000, rdisp} :
              paddr == A_PRE ? {15'h0000, pdisp} :
              paddr == A_SREF ? {20'h0_0000, sref} : {25'h000_0000, flg};
         if (!pwr && paddr >= A_STAT && paddr <= A_SREF)
            `CHK("port", ea[31:0], pv)
      end
   always @(pin_ev)
   begin
      ep = q.pop_front();
      `CHK("pins", ep, {29'h0000_0000, pins})
   end
   // one apb transfer, released only after pready is sampled
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [32:0] e);
      q.push_back(e);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   // drive speeds, let them settle, then read flags and pins
   task automatic chk(input int c, input int m, input int f);
      int k;
      logic [6:0] e;
      cs <= 16'(c);
      ms <= 16'(m);
      fs <= 16'(f);
      slow <= 1'($urandom);
      for (k = 0; k < 200 && (k < 8 || meas !== ms); k++)
         @(posedge clk);
      if (meas !== ms)
         fail_count++;
      e = ef(c, m, f);
      xfer(1'b0, A_STAT, 32'h0000_0000, {26'h000_0000, e});
      q.push_back({29'h0000_0000, rs ? e[2] : 1'b0, e[0], e[6], e[3]});
      -> pin_ev;
   endtask
   task summarize;
      if (fail_count == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // watchdog
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      summarize;
   end
   //****************************************
   // main sequence
   //****************************************
   initial
   begin
      void'($urandom(99250));
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      xfer(0, A_MACH, 0, 33'(R_MACH));
      xfer(0, A_POLE, 0, 33'(R_POLE));
      xfer(0, A_REF, 0, 33'(R_REF));
      xfer(0, A_SENS, 0, 33'(R_SENS));
      xfer(0, A_TH1, 0, 33'(R_TH1));
      xfer(0, A_TRV, 0, 33'(R_TRV));
      xfer(0, A_TH2, 0, 33'(R_TH2));
      xfer(0, A_TH3, 0, 33'(R_TH3));
      xfer(0, A_OSEL, 0, 33'(R_OSEL));
      xfer(1, A_POLE, 32'h0000_0003, E);
      xfer(1, A_REF, 32'h0000_0000, E);
      xfer(1, A_MACH, 32'(DISP_MAX), E);
      xfer(1, A_SENS, 32'h0000_0065, E);
      xfer(1, A_TRV, 32'h0000_0E11, E);
      xfer(1, A_STAT, 32'h0000_0000, E);
      xfer(0, 8'h38, 32'h0000_0000, E);
      xfer(1, A_SETV, 32'h0000_03E8, 0);
      st <= 1'b1;
      // every mode, boundary speeds then random ones
      for (int md = 0; md < 4; md++)
      begin
         mode <= sdd_mode_t'(md);
         for (int i = 0; i < 12; i++)
            chk(i < 8 ? bt[i] : int'($urandom_range(4000)) - 2000,
               i < 8 ? bt[7 - i] : int'($urandom_range(4000)) - 2000,
               int'($urandom_range(4000)) - 2000);
      end
      mode <= SDD_M_SPEED;
      for (int k = 0; k < 3; k++)
      begin
         {alm, stp, clr} <= 3'b001 << k;
         chk(2000, -2000, 2000);
      end
      {alm, stp, clr} <= 3'b000;
      xfer(1, A_TRV, 32'h0000_0190, 0);
      trv = 400;
      chk(-350, -400, 0);
      xfer(1, A_TH2, 32'h0000_0000, 0);
      th[1] = 0;
      st <= 1'b0;
      chk(0, 0, 0);
      st <= 1'b1;
      chk(0, 0, 0);
      xfer(1, A_OSEL, 32'h0000_0F4A, 0);
      rs = 1;
      chk(1600, 1600, 0);
      xfer(1, A_REF, 32'h0000_0708, 0);
      xfer(1, A_MACH, 32'h0000_03E8, 0);
      chk(0, 900, 0);
      xfer(0, A_RUN, 0, {16'h0000, 14'h01F4, 1'b0, SDD_U_MACH});
      xfer(0, A_SREF, 0, 33'h0_0000_03E8);
      xfer(1, A_POLE, 32'h0000_0004, 0);
      xfer(1, A_SETV, 32'h0000_014D, 0);
      xfer(0, A_SREF, 0, 33'h0_0000_0257);
      xfer(0, A_PRE, 0, {16'h0000, 14'h014C, 1'b0, SDD_U_MACH});
      xfer(1, A_MACH, 32'h0000_0000, 0);
      xfer(1, A_SETV, 32'h0000_1770, 0);
      xfer(0, A_SREF, 0, 33'h0_0000_0708);
      sp = 1800;
      chk(0, 1800, 0);
      xfer(0, A_RUN, 0, {16'h0000, 14'h1770, 1'b0, SDD_U_HZ});
      xfer(1, A_MACH, 32'(MACH_MAX), 0);
      xfer(1, A_REF, 32'h0000_0001, 0);
      sp = 1;
      chk(0, 1800, 0);
      xfer(0, A_RUN, 0, {16'h0000, 14'h0000, 1'b1, SDD_U_MACH});
      // plain r/min display above four digits, setting clamps to 3600
      xfer(1, A_MACH, 32'h0000_0000, 0);
      xfer(1, A_POLE, 32'h0000_0000, 0);
      sp = 3600;
      chk(0, 12000, 0);
      xfer(0, A_RUN, 0, {16'h0000, 14'h0000, 1'b1, SDD_U_RPM});
      summarize;
   end
endmodule
`default_nettype wire
